/* hdl/gain_switch_pkg.sv */
// Constants, types and register map for the servo gain switching block
package gain_switch_pkg;

	// ----------------------------------------------------------------
	// Gain sets
	// ----------------------------------------------------------------
	localparam int          NUM_GAINS   = 7;
	localparam int          GAIN_W      = 16;
	localparam int          WEIGHT_W    = 17;
	localparam logic [16:0] WEIGHT_ZERO = 17'h00000;
	localparam logic [16:0] WEIGHT_FULL = 17'h10000;

	localparam int IDX_SPEED_GAIN     = 0;
	localparam int IDX_SPEED_INTEGRAL = 1;
	localparam int IDX_POSITION_GAIN  = 2;
	localparam int IDX_TORQUE_FILTER  = 3;
	localparam int IDX_MF_GAIN        = 4;
	localparam int IDX_MF_CORR        = 5;
	localparam int IDX_FRICTION_GAIN  = 6;

	typedef logic [GAIN_W-1:0] gain_arr_t [NUM_GAINS];

	// Same defaults for both sets: 400, 2000, 400, 100, 500, 1000, 100
	localparam gain_arr_t GAIN_RESET = '{16'h0190, 16'h07D0, 16'h0190, 16'h0064,
		16'h01F4, 16'h03E8, 16'h0064};

	// ----------------------------------------------------------------
	// Selection setting fields
	// ----------------------------------------------------------------
	localparam int         METHOD_LSB      = 0;
	localparam int         COND_LSB        = 4;
	localparam int         DIGIT_W         = 4;
	localparam logic [3:0] METHOD_MANUAL   = 4'h0;
	localparam logic [3:0] METHOD_RESERVED = 4'h1;
	localparam logic [3:0] METHOD_AUTO1    = 4'h2;
	localparam logic [3:0] COND_POSITIONING_COMPLETE_FLAG_ON    = 4'h0;
	localparam logic [3:0] COND_POSITIONING_COMPLETE_FLAG_OFF   = 4'h1;
	localparam logic [3:0] COND_NEAR_ON    = 4'h2;
	localparam logic [3:0] COND_NEAR_OFF   = 4'h3;
	localparam logic [3:0] COND_FILTER_IDLE = 4'h4;
	localparam logic [3:0] COND_REF_ON     = 4'h5;
	localparam logic [15:0] SELECT_RESET   = 16'h0000;
	localparam logic [15:0] TIME_RESET     = 16'h0000;
	localparam logic [15:0] STYLE_RESET    = 16'h0000;

	typedef enum logic [1:0] {
		CTRL_POSITION = 2'b00,
		CTRL_SPEED    = 2'b01,
		CTRL_TORQUE   = 2'b10
	} ctrl_mode_t;

	typedef enum logic [2:0] {
		S_SET1      = 3'b000,
		S_WAIT_UP   = 3'b001,
		S_RAMP_UP   = 3'b010,
		S_SET2      = 3'b011,
		S_WAIT_DOWN = 3'b100,
		S_RAMP_DOWN = 3'b101
	} sw_state_t;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int MS_TIME_NS        = 1000000;
	localparam int CLK_PERIOD_NS     = 10;
	localparam int MS_CYCLES_DEFAULT = MS_TIME_NS / CLK_PERIOD_NS;
	localparam int PRESCALE_W        = 17;

	// ----------------------------------------------------------------
	// AHB-Lite register map (byte offsets)
	// ----------------------------------------------------------------
	localparam int         OFF_W        = 8;
	localparam logic [7:0] OFF_SELECT   = 8'h00;
	localparam logic [7:0] OFF_WAIT1    = 8'h04;
	localparam logic [7:0] OFF_WAIT2    = 8'h08;
	localparam logic [7:0] OFF_RAMP1    = 8'h0C;
	localparam logic [7:0] OFF_RAMP2    = 8'h10;
	localparam logic [7:0] OFF_STYLE    = 8'h14;
	localparam logic [7:0] OFF_STATUS   = 8'h18;
	localparam logic [7:0] OFF_SET1     = 8'h20;
	localparam logic [7:0] OFF_SET2     = 8'h40;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic       HRESP_OKAY   = 1'b0;

	// Status word fields
	localparam int STAT_WEIGHT_LSB = 0;
	localparam int STAT_MF_SEL     = 20;
	localparam int STAT_AUTO       = 21;
	localparam int STAT_STATE_LSB  = 24;

endpackage

/* hdl/blend_if.sv */
// Carrier between the switching control and the gain blender
`timescale 1ns/1ns
interface blend_if;
	import gain_switch_pkg::*;
	logic [GAIN_W-1:0]   set_one [NUM_GAINS];
	logic [GAIN_W-1:0]   set_two [NUM_GAINS];
	logic [WEIGHT_W-1:0] weight  [NUM_GAINS];
	logic [GAIN_W-1:0]   active  [NUM_GAINS];

	modport source  (output set_one, output set_two, output weight, input active);
	modport blender (input set_one, input set_two, input weight, output active);
endinterface

/* hdl/gain_blend.sv */
// Linear blend of the two gain sets by a per-gain weight
`timescale 1ns/1ns
module gain_blend
	import gain_switch_pkg::*;
(
	// Clock and reset
	input  wire logic  hclk,
	input  wire logic  hresetn,
	// Gain sets and weights
	blend_if.blender   bus
);

	// ------------------------------------------------------------
	// Interpolation
	// ------------------------------------------------------------
	// Weight is the share of set two in 1/65536 steps; full weight gives set two exactly
	function automatic logic [GAIN_W-1:0] blend(input logic [GAIN_W-1:0] a,
		input logic [GAIN_W-1:0] b, input logic [WEIGHT_W-1:0] w);
		logic signed [36:0] diff;
		logic signed [36:0] prod;
		diff = 37'(signed'({1'b0, b})) - 37'(signed'({1'b0, a}));
		prod = diff * 37'(signed'({1'b0, w}));
		blend = GAIN_W'(37'(signed'({1'b0, a})) + (prod >>> (WEIGHT_W - 1)));
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus.active <= GAIN_RESET;
		end else begin
			for (int i = 0; i < NUM_GAINS; i++) begin
				bus.active[i] <= blend(bus.set_one[i], bus.set_two[i], bus.weight[i]);
			end
		end
	end

endmodule

/* hdl/servo_gain_switching.sv */
// Gain set selection for the servo loops: manual or automatic with timed ramps
`timescale 1ns/1ns
//Contract
// - Lowest digit of selection: 0 manual, 2 automatic pattern 1, effective at once.
// - Manual mode: command gain bit 0 picks set one, 1 picks set two.
// - Each set holds seven gains, speed to friction compensation.
// - Model following gain and correction switch only in manual mode.
// - Model following values switch only with no reference and motor stopped.
// - Automatic switching works only under position control.
// - Condition A true: wait time one, then ramp to set two over ramp one.
// - Condition A false: wait time two, then ramp to set one over ramp one.
// - Second digit picks condition A among six codes.
// - Outside position control, even codes hold set one, odd codes set two.
// - Gains move linearly across the whole switching time; the code ramps only automatic switches.
// - Manual switching works under position, speed and torque control.
// - Switching works with either speed loop style.
// - Wait and ramp times are 16-bit millisecond counts, reset zero.
module servo_gain_switching
	import gain_switch_pkg::*;
#(
	parameter int unsigned MS_CYCLES = MS_CYCLES_DEFAULT
)(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Host command and drive status
	input  wire logic        gain_select_bit,
	input  wire logic [1:0]  control_mode,
	input  wire logic        positioning_complete_flag,
	input  wire logic        near_position_flag,
	input  wire logic        position_filter_zero,
	input  wire logic        reference_input_on,
	input  wire logic        reference_present,
	input  wire logic        motor_stopped,
	// Active gains
	output logic      [15:0] speed_gain,
	output logic      [15:0] speed_integral,
	output logic      [15:0] position_gain,
	output logic      [15:0] torque_filter,
	output logic      [15:0] model_follow_gain,
	output logic      [15:0] model_follow_corr,
	output logic      [15:0] friction_gain,
	output logic      [15:0] speed_loop_style,
	output logic             active_set_two
);

	// ------------------------------------------------------------
	// Settings
	// ------------------------------------------------------------
	logic [15:0] gain_switch_select_setting;
	logic [15:0] wait_time_one;
	logic [15:0] wait_time_two;
	logic [15:0] ramp_time_one;
	logic [15:0] ramp_time_two;
	logic [15:0] speed_loop_style_setting;
	gain_arr_t   set_one;
	gain_arr_t   set_two;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic        wr_phase;
	logic [7:0]  wr_off;
	logic [31:0] status_word;

	function automatic logic gain_hit(input logic [7:0] off, input logic [7:0] base);
		gain_hit = (off >= base) && (off < base + 8'(4 * NUM_GAINS)) && (off[1:0] == 2'b00);
	endfunction

	function automatic logic [2:0] gain_idx(input logic [7:0] off, input logic [7:0] base);
		logic [7:0] rel;
		rel = off - base;
		gain_idx = rel[4:2];
	endfunction

	wire         addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
	wire         rd_take    = addr_phase && !hwrite;
	wire         wr_take    = addr_phase && hwrite;
	wire         in_map     = (haddr[31:OFF_W] == '0);
	wire  [7:0]  rd_off     = haddr[OFF_W-1:0];
	wire         rd_set1    = gain_hit(rd_off, OFF_SET1);
	wire         rd_set2    = gain_hit(rd_off, OFF_SET2);
	wire  [2:0]  rd_set1_i  = gain_idx(rd_off, OFF_SET1);
	wire  [2:0]  rd_set2_i  = gain_idx(rd_off, OFF_SET2);
	wire         wr_set1    = wr_phase && gain_hit(wr_off, OFF_SET1);
	wire         wr_set2    = wr_phase && gain_hit(wr_off, OFF_SET2);
	wire  [2:0]  wr_set1_i  = gain_idx(wr_off, OFF_SET1);
	wire  [2:0]  wr_set2_i  = gain_idx(wr_off, OFF_SET2);
	wire  [31:0] rd_word =
		!in_map                  ? 32'h0000_0000 :
		(rd_off == OFF_SELECT)   ? {16'h0000, gain_switch_select_setting} :
		(rd_off == OFF_WAIT1)    ? {16'h0000, wait_time_one} :
		(rd_off == OFF_WAIT2)    ? {16'h0000, wait_time_two} :
		(rd_off == OFF_RAMP1)    ? {16'h0000, ramp_time_one} :
		(rd_off == OFF_RAMP2)    ? {16'h0000, ramp_time_two} :
		(rd_off == OFF_STYLE)    ? {16'h0000, speed_loop_style_setting} :
		(rd_off == OFF_STATUS)   ? status_word :
		rd_set1                  ? {16'h0000, set_one[rd_set1_i]} :
		rd_set2                  ? {16'h0000, set_two[rd_set2_i]} :
		32'h0000_0000;

	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_phase <= 1'b0;
			wr_off   <= 8'h00;
			hrdata   <= 32'h0000_0000;
		end else begin
			wr_phase <= wr_take && in_map;
			wr_off   <= rd_off;
			if (rd_take) begin
				hrdata <= rd_word;
			end
		end
	end

	// Settings take effect on the write cycle itself, no restart needed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gain_switch_select_setting <= SELECT_RESET;
			wait_time_one              <= TIME_RESET;
			wait_time_two              <= TIME_RESET;
			ramp_time_one              <= TIME_RESET;
			ramp_time_two              <= TIME_RESET;
			speed_loop_style_setting   <= STYLE_RESET;
		end else if (wr_phase) begin
			if (wr_off == OFF_SELECT) gain_switch_select_setting <= hwdata[15:0];
			if (wr_off == OFF_WAIT1)  wait_time_one <= hwdata[15:0];
			if (wr_off == OFF_WAIT2)  wait_time_two <= hwdata[15:0];
			if (wr_off == OFF_RAMP1)  ramp_time_one <= hwdata[15:0];
			if (wr_off == OFF_RAMP2)  ramp_time_two <= hwdata[15:0];
			if (wr_off == OFF_STYLE)  speed_loop_style_setting <= hwdata[15:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			set_one <= GAIN_RESET;
			set_two <= GAIN_RESET;
		end else begin
			for (int i = 0; i < NUM_GAINS; i++) begin
				if (wr_set1 && wr_set1_i == 3'(i)) set_one[i] <= hwdata[15:0];
				if (wr_set2 && wr_set2_i == 3'(i)) set_two[i] <= hwdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Mode and condition decode
	// ------------------------------------------------------------
	wire [3:0] method = gain_switch_select_setting[METHOD_LSB +: DIGIT_W];
	wire [3:0] cond   = gain_switch_select_setting[COND_LSB +: DIGIT_W];
	// Reserved method code and unknown codes fall back to manual selection
	wire       auto_mode   = (method == METHOD_AUTO1);
	wire       pos_control = (control_mode == CTRL_POSITION);
	wire       auto_active = auto_mode && pos_control;
	// Unknown condition codes behave as code 0
	wire       cond_a =
		(cond == COND_POSITIONING_COMPLETE_FLAG_OFF)    ? !positioning_complete_flag :
		(cond == COND_NEAR_ON)     ? near_position_flag :
		(cond == COND_NEAR_OFF)    ? !near_position_flag :
		(cond == COND_FILTER_IDLE) ? (position_filter_zero && !reference_input_on) :
		(cond == COND_REF_ON)      ? reference_input_on :
		positioning_complete_flag;
	wire       fixed_two  = (cond <= COND_REF_ON) && cond[0];
	// Manual switching holds in every control method
	wire       target_two = auto_mode ? fixed_two : gain_select_bit;
	wire       mf_allowed = !auto_mode && !reference_present && motor_stopped;

	// ------------------------------------------------------------
	// Millisecond timing
	// ------------------------------------------------------------
	sw_state_t           state;
	sw_state_t           next_state;
	logic [WEIGHT_W-1:0] weight;
	logic [WEIGHT_W-1:0] next_weight;
	logic [15:0]         ms_count;
	logic [15:0]         next_ms_count;
	logic [PRESCALE_W-1:0] prescale;
	logic                mf_sel;

	wire ms_tick    = (prescale == PRESCALE_W'(MS_CYCLES - 1));
	wire restart_ms = (next_state != state);
	// Truncated step; the last tick lands exactly on the end value
	wire [WEIGHT_W-1:0] ramp_step = (ramp_time_one == 16'h0000) ? WEIGHT_FULL :
		WEIGHT_FULL / {1'b0, ramp_time_one};
	wire [15:0] ms_plus = ms_count + 16'h0001;

	function automatic logic [WEIGHT_W-1:0] step_weight(input logic [WEIGHT_W-1:0] w,
		input logic [WEIGHT_W-1:0] s, input logic up);
		logic [WEIGHT_W:0] sum;
		sum = {1'b0, w} + {1'b0, s};
		if (up) begin
			step_weight = (sum > {1'b0, WEIGHT_FULL}) ? WEIGHT_FULL : sum[WEIGHT_W-1:0];
		end else begin
			step_weight = (w < s) ? WEIGHT_ZERO : w - s;
		end
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescale <= '0;
		end else if (restart_ms || ms_tick) begin
			prescale <= '0;
		end else begin
			prescale <= prescale + PRESCALE_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Switching sequence
	// ------------------------------------------------------------
	always_comb begin
		next_state    = state;
		next_weight   = weight;
		next_ms_count = ms_count;
		if (!auto_active) begin
			next_state    = target_two ? S_SET2 : S_SET1;
			next_weight   = target_two ? WEIGHT_FULL : WEIGHT_ZERO;
			next_ms_count = 16'h0000;
		end else begin
			unique case (state)
				S_SET1: begin
					if (cond_a) begin
						next_state    = S_WAIT_UP;
						next_ms_count = 16'h0000;
					end
				end
				S_WAIT_UP: begin
					if (!cond_a) begin
						next_state    = S_WAIT_DOWN;
						next_ms_count = 16'h0000;
					end else if (ms_count >= wait_time_one) begin
						next_ms_count = 16'h0000;
						next_state    = (ramp_time_one == 16'h0000) ? S_SET2 : S_RAMP_UP;
						if (ramp_time_one == 16'h0000) next_weight = WEIGHT_FULL;
					end else if (ms_tick) begin
						next_ms_count = ms_plus;
					end
				end
				S_RAMP_UP: begin
					if (ms_tick) begin
						next_ms_count = ms_plus;
						next_weight   = step_weight(weight, ramp_step, 1'b1);
						if (ms_plus >= ramp_time_one) begin
							next_weight = WEIGHT_FULL;
							next_state  = S_SET2;
						end
					end
				end
				S_SET2: begin
					if (!cond_a) begin
						next_state    = S_WAIT_DOWN;
						next_ms_count = 16'h0000;
					end
				end
				S_WAIT_DOWN: begin
					if (cond_a) begin
						next_state    = S_WAIT_UP;
						next_ms_count = 16'h0000;
					end else if (ms_count >= wait_time_two) begin
						next_ms_count = 16'h0000;
						next_state    = (ramp_time_one == 16'h0000) ? S_SET1 : S_RAMP_DOWN;
						if (ramp_time_one == 16'h0000) next_weight = WEIGHT_ZERO;
					end else if (ms_tick) begin
						next_ms_count = ms_plus;
					end
				end
				S_RAMP_DOWN: begin
					if (ms_tick) begin
						next_ms_count = ms_plus;
						next_weight   = step_weight(weight, ramp_step, 1'b0);
						if (ms_plus >= ramp_time_one) begin
							next_weight = WEIGHT_ZERO;
							next_state  = S_SET1;
						end
					end
				end
				default: begin
					next_state  = S_SET1;
					next_weight = WEIGHT_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= S_SET1;
			weight   <= WEIGHT_ZERO;
			ms_count <= 16'h0000;
			mf_sel   <= 1'b0;
		end else begin
			state    <= next_state;
			weight   <= next_weight;
			ms_count <= next_ms_count;
			if (mf_allowed) mf_sel <= gain_select_bit;
		end
	end

	// ------------------------------------------------------------
	// Blending and outputs
	// ------------------------------------------------------------
	blend_if blend_bus ();

	assign blend_bus.set_one = set_one;
	assign blend_bus.set_two = set_two;
	// Model following values follow their own latched selection, never the ramp
	generate
		for (genvar g = 0; g < NUM_GAINS; g++) begin : g_weight
			if (g == IDX_MF_GAIN || g == IDX_MF_CORR) begin : g_mf
				assign blend_bus.weight[g] = mf_sel ? WEIGHT_FULL : WEIGHT_ZERO;
			end else begin : g_main
				assign blend_bus.weight[g] = weight;
			end
		end
	endgenerate

	gain_blend blend_unit (
		.hclk    (hclk),
		.hresetn (hresetn),
		.bus     (blend_bus.blender)
	);

	// Friction gain is switched regardless; it only matters where compensation runs
	assign speed_gain        = blend_bus.active[IDX_SPEED_GAIN];
	assign speed_integral    = blend_bus.active[IDX_SPEED_INTEGRAL];
	assign position_gain     = blend_bus.active[IDX_POSITION_GAIN];
	assign torque_filter     = blend_bus.active[IDX_TORQUE_FILTER];
	assign model_follow_gain = blend_bus.active[IDX_MF_GAIN];
	assign model_follow_corr = blend_bus.active[IDX_MF_CORR];
	assign friction_gain     = blend_bus.active[IDX_FRICTION_GAIN];
	// Loop style only passes through; switching does not depend on it
	assign speed_loop_style  = speed_loop_style_setting;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active_set_two <= 1'b0;
		end else begin
			active_set_two <= (next_state == S_SET2) || (next_state == S_WAIT_DOWN);
		end
	end

	assign status_word = {5'h00, state, 2'b00, auto_active, mf_sel, 3'b000, weight};

endmodule

/* tb/servo_gain_switching_sva.sv */
// Port checker for the gain switching block
`timescale 1ns/1ns
module servo_gain_switching_sva
	import gain_switch_pkg::*;
(
	// Bus
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Command, status and gains
	input wire logic        gain_select_bit,
	input wire logic [1:0]  control_mode,
	input wire logic        reference_present,
	input wire logic        motor_stopped,
	input wire logic [15:0] speed_gain,
	input wire logic [15:0] model_follow_gain,
	input wire logic        active_set_two
);
	// ----
	// Shadow of the selection setting
	// ----
	logic       sel_wr;
	logic [7:0] sel;
	wire        take  = hsel && hready && htrans == HTRANS_NONSEQ;
	wire        man   = sel[3:0] == METHOD_MANUAL;
	wire        aut   = sel[3:0] == METHOD_AUTO1;
	wire        mf_ok = man && !reference_present && motor_stopped;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_wr <= 1'b0;
			sel    <= 8'h00;
		end else begin
			sel_wr <= take && hwrite && haddr == 32'h0;
			if (sel_wr)
				sel <= hwdata[7:0];
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (hresp == HRESP_OKAY)
		else $error("hresp not okay");
	a_rdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata))
		else $error("hrdata moved without a read");
	a_unmapped_zero: assert property (take && !hwrite && haddr[31:8] != 24'h0
		|=> hrdata == 32'h0) else $error("unmapped read not zero");
	a_reset_defaults: assert property ($rose(hresetn) |->
		speed_gain == GAIN_RESET[IDX_SPEED_GAIN] && !active_set_two
		&& model_follow_gain == GAIN_RESET[IDX_MF_GAIN]) else $error("bad reset gains");
	a_manual_select: assert property (
		(man && !sel_wr && $stable(gain_select_bit))[*3] |-> active_set_two == gain_select_bit)
		else $error("manual set differs from select bit");
	a_fixed_set: assert property (
		(aut && !sel_wr && control_mode != CTRL_POSITION && sel[7:4] <= 4'h5)[*3]
		|-> active_set_two == sel[4]) else $error("wrong fixed set");
	a_mf_hold: assert property (!mf_ok [*4] |-> $stable(model_follow_gain))
		else $error("model following gain moved while blocked");
endmodule
bind servo_gain_switching servo_gain_switching_sva chk (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .gain_select_bit,
	.control_mode, .reference_present, .motor_stopped, .speed_gain, .model_follow_gain,
	.active_set_two);

/* tb/host_cmd_model.sv */
// Host controller model: servo command bit, control method and drive status
`timescale 1ns/1ns
module host_cmd_model (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Requested command; slow adds a cycle of lag
	input  wire logic [8:0] req,
	input  wire logic       slow,
	// Lines to the drive
	output logic            gain_select_bit,
	output logic [1:0]      control_mode,
	output logic [5:0]      status_flags
);
	logic [8:0] lag;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lag                                             <= 9'h000;
			{gain_select_bit, control_mode, status_flags} <= 9'h000;
		end else begin
			lag                                             <= req;
			{gain_select_bit, control_mode, status_flags} <= slow ? lag : req;
		end
	end
endmodule

/* tb/servo_gain_switching_tb_top.sv */
// Self-checking bench for the gain switching block
`timescale 1ns/1ns
module servo_gain_switching_tb_top;
	import gain_switch_pkg::*;
	localparam int MS = 10;
	logic        hclk, hresetn, hsel, hwrite, slow;
	logic [1:0]  htrans;
	logic [8:0]  req;
	logic [31:0] haddr, hwdata, rd, seed, g2;
	int          err_count, total_checks, n;
	wire logic        hready, hresp, gsel, set_two;
	wire logic [1:0]  mode;
	wire logic [5:0]  fl;
	wire logic [31:0] hrdata;
	wire logic [15:0] spd, mfg, style, spi, pgn, tqf, mfc, frg;

	host_cmd_model host (.hclk, .hresetn, .req, .slow, .gain_select_bit(gsel),
		.control_mode(mode), .status_flags(fl));
	servo_gain_switching #(.MS_CYCLES(MS)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
		.gain_select_bit(gsel), .control_mode(mode), .positioning_complete_flag(fl[5]),
		.near_position_flag(fl[4]), .position_filter_zero(fl[3]),
		.reference_input_on(fl[2]), .reference_present(fl[1]), .motor_stopped(fl[0]),
		.speed_gain(spd), .speed_integral(spi), .position_gain(pgn), .torque_filter(tqf),
		.model_follow_gain(mfg), .model_follow_corr(mfc), .friction_gain(frg),
		.speed_loop_style(style), .active_set_two(set_two));

	// ----
	// Helpers
	// ----
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// Never yields the reserved method code
	function automatic logic [31:0] cfg(input int cond, input logic auto);
		return {24'h0, 4'(cond), auto ? METHOD_AUTO1 : METHOD_MANUAL};
	endfunction
	function automatic logic fixed_two(input int cond);
		return cond % 2 == 1;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		haddr  <= a;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic cmd(input logic [8:0] v);
		@(posedge hclk);
		req <= v;
	endtask
	task automatic wait_two(input logic v);
		n = 0;
		while (set_two !== v && n < 100) begin
			@(posedge hclk);
			n++;
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		#100000;
		err_count++;
		close_out();
	end

	// ----
	// Main sequence
	// ----
	initial begin
		{hresetn, hsel, hwrite, slow, htrans, haddr, hwdata} = '0;
		req = 9'h000;
		err_count = 0;
		total_checks = 0;
		seed = 32'd12;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 32'(4 * i), 32'h0);
			chk("setting", rd, 32'h0);
		end
		for (int i = 0; i < NUM_GAINS; i++) begin
			bus(1'b0, 32'(OFF_SET1) + 4 * i, 32'h0);
			chk("set one", rd, {16'h0, GAIN_RESET[i]});
		end
		chk("gains a", {spi, pgn},
			{GAIN_RESET[IDX_SPEED_INTEGRAL], GAIN_RESET[IDX_POSITION_GAIN]});
		chk("gains b", {tqf, mfc},
			{GAIN_RESET[IDX_TORQUE_FILTER], GAIN_RESET[IDX_MF_CORR]});
		chk("friction", frg, {16'h0, GAIN_RESET[IDX_FRICTION_GAIN]});
		bus(1'b1, OFF_WAIT2, 32'h1234FFFF);
		bus(1'b0, OFF_WAIT2, 32'h0);
		chk("wait two", rd, 32'h0000FFFF);
		bus(1'b1, 32'h100, 32'h5);
		bus(1'b0, 32'h100, 32'h0);
		chk("unmapped", rd, 32'h0);
		bus(1'b1, OFF_STYLE, 32'h1);
		@(posedge hclk);
		chk("style", style, 32'h1);
		seed = xs(seed);
		g2 = {20'h1, seed[11:0]};
		bus(1'b1, OFF_SET2, g2);
		bus(1'b1, 32'(OFF_SET2) + 4 * IDX_MF_GAIN, g2 + 1);
		// Manual selection in every control method, model following blocked
		for (int m = 0; m < 3; m++) begin
			for (int k = 0; k < 4; k++) begin
				seed = xs(seed);
				cmd({seed[0], 2'(m), 6'h02});
				slow <= seed[1];
				repeat (6) @(posedge hclk);
				chk("set two", set_two, seed[0]);
				chk("speed gain", spd, seed[0] ? g2 : 32'h190);
				chk("mf blocked", mfg, 32'h1F4);
			end
		end
		slow <= 1'b0;
		cmd(9'h101);
		repeat (6) @(posedge hclk);
		chk("mf switched", mfg, g2 + 1);
		// Select bit stays high so the latched model following choice is kept
		cmd({1'b1, CTRL_SPEED, 6'h21});
		for (int c = 0; c < 6; c++) begin
			bus(1'b1, OFF_SELECT, cfg(c, 1'b1));
			repeat (4) @(posedge hclk);
			chk("fixed set", set_two, fixed_two(c));
			chk("mf in auto", mfg, g2 + 1);
		end
		// Automatic switching under position control, condition on completion flag
		bus(1'b1, OFF_WAIT1, 32'd2);
		bus(1'b1, OFF_WAIT2, 32'd1);
		bus(1'b1, OFF_RAMP1, 32'd4);
		bus(1'b1, OFF_RAMP2, 32'd0);
		bus(1'b1, OFF_SELECT, cfg(0, 1'b0));
		cmd(9'h001);
		repeat (6) @(posedge hclk);
		bus(1'b1, OFF_SELECT, cfg(0, 1'b1));
		cmd(9'h021);
		wait_two(1'b1);
		chk("rise time", n >= 6 * MS && n <= 6 * MS + 5, 1);
		repeat (2) @(posedge hclk);
		chk("set two gain", spd, g2);
		chk("mf kept", mfg, 32'h1F4);
		cmd(9'h001);
		wait_two(1'b0);
		chk("fall time", n >= MS && n <= MS + 5, 1);
		repeat (2 * MS) @(posedge hclk);
		chk("mid ramp", spd > 16'h0190 && spd < g2[15:0], 1);
		repeat (3 * MS) @(posedge hclk);
		chk("set one gain", spd, 32'h190);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk("status", rd, 32'h1 << STAT_AUTO);
		// Condition drops during the wait: no move toward set two
		bus(1'b1, OFF_WAIT1, 32'd5);
		cmd(9'h021);
		repeat (2 * MS) @(posedge hclk);
		cmd(9'h001);
		repeat (8 * MS) @(posedge hclk);
		chk("abandoned wait", spd, 32'h190);
		// Zero ramp time steps at once
		bus(1'b1, OFF_WAIT1, 32'd2);
		bus(1'b1, OFF_RAMP1, 32'd0);
		cmd(9'h021);
		n = 0;
		while (spd === 16'h0190 && n < 60) begin
			@(posedge hclk);
			n++;
		end
		chk("one step", spd, g2);
		chk("step delay", n >= 2 * MS, 1);
		close_out();
	end
endmodule
